// File: shared/irq_map.svh
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

// register byte offsets on the plain register port
`define OFS_PRIMARY_EN   8'ha8
`define OFS_PRIMARY_PRI  8'hb8
`define OFS_EXT_EN1      8'he6
`define OFS_EXT_EN2      8'he7
`define OFS_EXT_PRI1     8'hf3
`define OFS_EXT_PRI2     8'hf4
`define OFS_PEND_LO      8'h10
`define OFS_PEND_HI      8'h11

// field positions
`define GLOBAL_EN_BIT    7
`define PRIMARY_SRC_CNT  7
`define EXT1_SRC_CNT     6
`define EXT2_SRC_CNT     2
`define PEND_LO_CNT      8
`define EXT_PIN0_SRC     0
`define EXT_PIN1_SRC     2
`define AUTO_CLR_CNT     4

// reset values
`define PRIMARY_PRI_RST  8'h80
`define REG_RST          8'h00

// vector layout
`define VEC_BASE         16'h0003
`define VEC_STEP         16'h0008
`define RESERVED_ORDERS  5'h02
`define FIRST_GAP_SRC    13

// timing in system clocks
`define DETECT_CYCLES    1
`define LONG_CALL_INSTR_CYCLES     4
`define MIN_RESPONSE     5
`define MAX_RESPONSE     18

`endif

// File: shared/irq_pkg.sv
package irq_pkg;
    // call sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALL = 2'b10
    } call_state_e;

    typedef logic [14:0] src_vec_t;
    typedef logic [3:0]  src_idx_t;
endpackage

// File: src/two_level_interrupt_controller.sv
// Notes on behaviour
// - fifteen sources, each placed at low or high level.
// - a source event sets its pending flag regardless of its enable.
// - enabled pending source gets a long call at the next instruction boundary.
// - return instruction resumes the interrupted program; the core keeps the return address.
// - disabled sources raise no request; the program runs on.
// - global enable at primary bit seven gates every source request.
// - each source has its own enable bit in the enable registers.
// - only pin and timer 0/1 flags clear on vectoring; software clears others.
// - a flag still set after return re-enters after one more instruction.
// - a software write setting a flag vectors like a hardware event.
// - high level preempts low service; high service is never preempted.
// - each source has one priority bit, resetting to low.
// - higher level wins first, then lowest order number.
// - pending requests are sampled and decoded on every clock.
// - least response is one detect clock plus four call clocks.
// - after a return, one instruction completes before the pending call.
// - worst response is eighteen clocks through return and divide.
// - equal or higher service holds new requests until return plus one instruction.
// - vectors start at 0x0003, step eight per order, orders 13/14 reserved.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`include "irq_map.svh"
`timescale 1ns/1ps
`default_nettype none

module two_level_interrupt_controller #(
    parameter int N_SRC        = 15,              // number of sources
    parameter int LONG_CALL_INSTR_CYCLES = `LONG_CALL_INSTR_CYCLES    // clocks of the long call
) (
    input  wire logic        clk,                 // system clock, 200 MHz
    input  wire logic        resetn,              // synchronous reset, active low
    input  wire logic [7:0]  reg_addr,            // register byte offset
    input  wire logic [7:0]  reg_wdata,           // register write data
    input  wire logic        reg_wr,              // write strobe
    input  wire logic        reg_rd,              // read strobe
    output logic      [7:0]  reg_rdata,           // read data, cycle after strobe
    input  wire logic [14:0] src_event,           // peripheral event pulses
    input  wire logic        external_irq_pin_zero, // async pin, rising edge event
    input  wire logic        external_irq_pin_one,  // async pin, rising edge event
    input  wire logic        instr_boundary,      // core: instruction completes now
    input  wire logic        return_from_irq_instr_done,           // core: return instruction completes now
    output logic             call_start,          // pulse: long call begins
    output logic      [15:0] call_vector,         // vector address of the call
    output logic             call_level,          // level of the call, 1 high
    output logic             call_busy,           // long call in progress
    output logic      [1:0]  in_service,          // active service level bits
    output logic      [14:0] pending              // pending flags
);

    // elaboration check
    if (N_SRC != 15 || LONG_CALL_INSTR_CYCLES < 1 || LONG_CALL_INSTR_CYCLES > 15) begin : g_bad_param
        $error("unsupported parameter values");
    end

    // map must cover every source exactly once
    if (`PRIMARY_SRC_CNT + `EXT1_SRC_CNT + `EXT2_SRC_CNT != N_SRC) begin : g_bad_map
        $error("enable map does not cover all sources");
    end

    // auto clear sources must sit in the low pending byte
    if (`AUTO_CLR_CNT > `PEND_LO_CNT || `EXT_PIN1_SRC >= `AUTO_CLR_CNT) begin : g_bad_clr
        $error("auto clear range outside low pending byte");
    end

    localparam int N_EXT1 = `PRIMARY_SRC_CNT + `EXT1_SRC_CNT;

    irq_pkg::call_state_e state_q;
    irq_pkg::src_vec_t    en_q;
    irq_pkg::src_vec_t    pri_q;
    irq_pkg::src_vec_t    pend_q;
    irq_pkg::src_vec_t    src_set;
    irq_pkg::src_vec_t    active;
    irq_pkg::src_idx_t    win_idx_q;
    irq_pkg::src_idx_t    win_idx_d;
    logic                 global_q;
    logic                 win_valid_q;
    logic                 win_valid_d;
    logic                 win_level_q;
    logic                 win_level_d;
    logic [1:0]           svc_q;
    logic [3:0]           call_cnt_q;
    logic [7:0]           rdata_q;
    logic                 start_q;
    logic [15:0]          vector_q;
    logic                 level_q;
    logic [2:0]           pin0_q;
    logic [2:0]           pin1_q;
    logic                 take_call;
    logic                 wr_pend_lo;
    logic                 wr_pend_hi;
    logic                 busy_q;
    logic                 lo_open;
    logic                 hi_open;
    logic                 seq_idle;
    logic                 win_live;
    logic                 core_ready;
    wire  [14:0]          pend_d;
    wire  [14:0]          req_lo;
    wire  [14:0]          req_hi;

    // order number to vector address
    function automatic logic [15:0] vector_of(input logic [3:0] idx);
        logic [4:0] order;
        order = {1'b0, idx};
        if (idx >= 4'(`FIRST_GAP_SRC)) begin
            order = order + `RESERVED_ORDERS;
        end
        vector_of = `VEC_BASE + 16'(order) * `VEC_STEP;
    endfunction

    // pin synchronisers plus edge history
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin0_q <= 3'h0;
            pin1_q <= 3'h0;
        end else begin
            pin0_q <= {pin0_q[1:0], external_irq_pin_zero};
            pin1_q <= {pin1_q[1:0], external_irq_pin_one};
        end
    end

    // hardware set sources, pins on rising edge
    // events set flags
    always_comb begin
        src_set = src_event;
        src_set[`EXT_PIN0_SRC] = src_event[`EXT_PIN0_SRC] | (pin0_q[1] & ~pin0_q[2]);
        src_set[`EXT_PIN1_SRC] = src_event[`EXT_PIN1_SRC] | (pin1_q[1] & ~pin1_q[2]);
    end

    assign wr_pend_lo = reg_wr && (reg_addr == `OFS_PEND_LO);
    assign wr_pend_hi = reg_wr && (reg_addr == `OFS_PEND_HI);

    // per source pending flag
    for (genvar i = 0; i < N_SRC; i++) begin : g_pend
        localparam int BIT = (i < `PEND_LO_CNT) ? i : i - `PEND_LO_CNT;
        logic sw_wr;
        logic sw_val;
        logic hw_clr;
        assign sw_wr  = (i < `PEND_LO_CNT) ? wr_pend_lo : wr_pend_hi;
        assign sw_val = reg_wdata[BIT];
        assign hw_clr = (i < `AUTO_CLR_CNT) && take_call && (win_idx_q == 4'(i));
        // software set as event
        // set beats any clear landing in the same cycle
        assign pend_d[i] = (src_set[i] || (sw_wr && sw_val)) ? 1'b1
                         : (sw_wr || hw_clr)                ? 1'b0
                         : pend_q[i];
    end

    // pending flag register, one writer for all bits
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // enable and priority registers
    // per source enables
    always_ff @(posedge clk) begin
        if (!resetn) begin
            global_q <= 1'b0;
            en_q     <= '0;
            pri_q    <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OFS_PRIMARY_EN: begin
                    global_q <= reg_wdata[`GLOBAL_EN_BIT];
                    en_q[`PRIMARY_SRC_CNT-1:0] <= reg_wdata[`PRIMARY_SRC_CNT-1:0];
                end
                `OFS_EXT_EN1:     en_q[N_EXT1-1:`PRIMARY_SRC_CNT] <= reg_wdata[`EXT1_SRC_CNT-1:0];
                `OFS_EXT_EN2:     en_q[N_SRC-1:N_EXT1] <= reg_wdata[`EXT2_SRC_CNT-1:0];
                `OFS_PRIMARY_PRI: pri_q[`PRIMARY_SRC_CNT-1:0] <= reg_wdata[`PRIMARY_SRC_CNT-1:0];
                `OFS_EXT_PRI1:    pri_q[N_EXT1-1:`PRIMARY_SRC_CNT] <= reg_wdata[`EXT1_SRC_CNT-1:0];
                `OFS_EXT_PRI2:    pri_q[N_SRC-1:N_EXT1] <= reg_wdata[`EXT2_SRC_CNT-1:0];
                default: ;
            endcase
        end
    end

    // read data, one cycle after strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_q <= `REG_RST;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OFS_PRIMARY_EN:  rdata_q <= {global_q, en_q[`PRIMARY_SRC_CNT-1:0]};
                `OFS_EXT_EN1:     rdata_q <= {2'h0, en_q[N_EXT1-1:`PRIMARY_SRC_CNT]};
                `OFS_EXT_EN2:     rdata_q <= {6'h00, en_q[N_SRC-1:N_EXT1]};
                `OFS_PRIMARY_PRI: rdata_q <= `PRIMARY_PRI_RST | {1'b0, pri_q[`PRIMARY_SRC_CNT-1:0]};
                `OFS_EXT_PRI1:    rdata_q <= {2'h0, pri_q[N_EXT1-1:`PRIMARY_SRC_CNT]};
                `OFS_EXT_PRI2:    rdata_q <= {6'h00, pri_q[N_SRC-1:N_EXT1]};
                `OFS_PEND_LO:     rdata_q <= pend_q[`PEND_LO_CNT-1:0];
                `OFS_PEND_HI:     rdata_q <= {1'b0, pend_q[N_SRC-1:`PEND_LO_CNT]};
                default:          rdata_q <= `REG_RST;
            endcase
        end else begin
            rdata_q <= `REG_RST;
        end
    end

    assign active = pend_q & en_q & {N_SRC{global_q}};

    // level gates from the service state
    // preemption by level
    assign lo_open = (svc_q == 2'b00);    // low waits for any running service
    assign hi_open = !svc_q[1];           // high never preempts high

    // per source requests split by level
    for (genvar i = 0; i < N_SRC; i++) begin : g_req
        assign req_lo[i] = active[i] && !pri_q[i] && lo_open;
        assign req_hi[i] = active[i] && pri_q[i] && hi_open;
    end

    // priority decode, lowest order wins within a level
    // level then order
    always_comb begin
        win_valid_d = 1'b0;
        win_level_d = 1'b0;
        win_idx_d   = 4'h0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (req_lo[i]) begin
                win_valid_d = 1'b1;
                win_level_d = 1'b0;
                win_idx_d   = 4'(i);
            end
        end
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (req_hi[i]) begin
                win_valid_d = 1'b1;
                win_level_d = 1'b1;
                win_idx_d   = 4'(i);
            end
        end
    end

    // one detect clock, decoded every cycle
    // sample each clock
    always_ff @(posedge clk) begin
        if (!resetn) begin
            win_valid_q <= 1'b0;
            win_level_q <= 1'b0;
            win_idx_q   <= 4'h0;
        end else begin
            win_valid_q <= win_valid_d;
            win_level_q <= win_level_d;
            win_idx_q   <= win_idx_d;
        end
    end

    // call taken at a boundary that is not the end of a return
    // call at boundary
    assign seq_idle   = (state_q == irq_pkg::ST_IDLE);
    assign win_live   = win_valid_q && pend_q[win_idx_q];   // winner is one cycle old, flag rechecked
    assign core_ready = instr_boundary && !return_from_irq_instr_done;        // never in the return's own cycle
    assign take_call  = seq_idle && win_live && core_ready;

    // busy flag mirrors the call sequencer
    // busy for the call clocks
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_q <= 1'b0;
        end else if (take_call) begin
            busy_q <= 1'b1;
        end else if ((state_q == irq_pkg::ST_CALL) && (call_cnt_q == 4'h0)) begin
            busy_q <= 1'b0;
        end
    end

    // long call sequencer
    // four call clocks
    // worst case set by core timing
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q    <= irq_pkg::ST_IDLE;
            call_cnt_q <= 4'h0;
        end else begin
            unique case (state_q)
                irq_pkg::ST_IDLE: begin
                    if (take_call) begin
                        state_q    <= irq_pkg::ST_CALL;
                        call_cnt_q <= 4'(LONG_CALL_INSTR_CYCLES - 1);
                    end
                end
                irq_pkg::ST_CALL: begin
                    if (call_cnt_q == 4'h0) begin
                        state_q <= irq_pkg::ST_IDLE;
                    end else begin
                        call_cnt_q <= call_cnt_q - 4'h1;
                    end
                end
            endcase
        end
    end

    // call outputs
    // vector address
    always_ff @(posedge clk) begin
        if (!resetn) begin
            start_q  <= 1'b0;
            vector_q <= 16'h0000;
            level_q  <= 1'b0;
        end else begin
            start_q <= take_call;
            if (take_call) begin
                vector_q <= vector_of(win_idx_q);
                level_q  <= win_level_q;
            end
        end
    end

    // in-service tracking per level
    // level service state
    always_ff @(posedge clk) begin
        if (!resetn) begin
            svc_q <= 2'b00;
        end else if (take_call) begin
            svc_q[win_level_q] <= 1'b1;
        end else if (return_from_irq_instr_done) begin
            if (svc_q[1]) begin
                svc_q[1] <= 1'b0;
            end else begin
                svc_q[0] <= 1'b0;
            end
        end
    end

    assign reg_rdata   = rdata_q;
    assign call_start  = start_q;
    assign call_vector = vector_q;
    assign call_level  = level_q;
    assign call_busy   = busy_q;
    assign in_service  = svc_q;
    assign pending     = pend_q;

endmodule // two_level_interrupt_controller

`default_nettype wire

// File: tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic clk,            // clock
    input  wire logic resetn,         // sync reset
    input  wire logic call_busy,      // call in progress
    input  wire logic ret_req,        // pulse: end service
    input  wire logic slow,           // long instructions
    output logic      instr_boundary, // instruction ends
    output logic      return_from_irq_instr_done       // return ends
);
    logic [2:0] cnt_q;
    logic       ret_q;
    always_ff @(posedge clk) begin
        if (!resetn || call_busy) cnt_q <= 3'h0;
        else cnt_q <= cnt_q + 3'h1;
    end
    assign instr_boundary = !call_busy && (!slow || cnt_q == 3'h7);
    always_ff @(posedge clk) begin
        if (!resetn || return_from_irq_instr_done) ret_q <= 1'b0;
        else if (ret_req) ret_q <= 1'b1;
    end
    assign return_from_irq_instr_done = ret_q && instr_boundary;
endmodule // core_model
`default_nettype wire

// File: tb/irq_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module irq_checker #(
    parameter int LONG_CALL_INSTR_CYCLES = 4
) (
    input wire logic        clk,            // clock
    input wire logic        resetn,         // sync reset
    input wire logic        reg_rd,         // read strobe
    input wire logic [7:0]  reg_rdata,      // read data
    input wire logic        instr_boundary, // core boundary
    input wire logic        return_from_irq_instr_done,      // core return
    input wire logic        call_start,     // call pulse
    input wire logic [15:0] call_vector,    // call target
    input wire logic        call_level,     // call level
    input wire logic        call_busy,      // call running
    input wire logic [1:0]  in_service,     // service levels
    input wire logic [14:0] pending         // pending flags
);
    logic [3:0] bcnt_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // counts consecutive busy cycles
    always_ff @(posedge clk) begin
        if (!resetn || !call_busy) bcnt_q <= 4'h0;
        else bcnt_q <= bcnt_q + 4'h1;
    end
    busy_len_a: assert property ($fell(call_busy) |-> bcnt_q == LONG_CALL_INSTR_CYCLES)
        else $error("call busy length wrong");
    start_busy_a: assert property (call_start |-> call_busy && !$past(call_busy))
        else $error("call started while busy");
    boundary_take_a: assert property (call_start |-> $past(instr_boundary) && !$past(return_from_irq_instr_done))
        else $error("call taken off an instruction boundary");
    return_from_irq_instr_gap_a: assert property (return_from_irq_instr_done |=> !call_start)
        else $error("call right after return");
    vec_legal_a: assert property (call_start |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h0083
        && !(call_vector inside {16'h006b, 16'h0073})) else $error("illegal vector");
    high_hold_a: assert property (call_start |-> !$past(in_service[1]))
        else $error("high service preempted");
    low_entry_a: assert property (call_start && !call_level |-> in_service == 2'b01)
        else $error("low call over running service");
    level_mark_a: assert property (call_start && call_level |-> in_service[1])
        else $error("high level not marked");
    auto_clr_a: assert property (call_start && call_vector == 16'h000b |-> !pending[1])
        else $error("timer flag not cleared");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
endmodule // irq_checker
bind two_level_interrupt_controller irq_checker #(.LONG_CALL_INSTR_CYCLES(LONG_CALL_INSTR_CYCLES)) u_irq_checker (.clk, .resetn,
    .reg_rd, .reg_rdata, .instr_boundary, .return_from_irq_instr_done, .call_start, .call_vector, .call_level, .call_busy,
    .in_service, .pending);
`default_nettype wire

// File: tb/test_two_level_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_two_level_interrupt_controller;
    logic        clk, resetn, reg_wr, reg_rd, ret_req, slow;
    logic        external_irq_pin_zero, external_irq_pin_one;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [14:0] src_event, pending;
    logic [15:0] call_vector;
    logic [1:0]  in_service;
    logic        instr_boundary, return_from_irq_instr_done, call_start, call_level, call_busy;
    int          n_fail, n_compared;
    two_level_interrupt_controller #(.N_SRC(15), .LONG_CALL_INSTR_CYCLES(4)) u_two_level_interrupt_controller (.clk,
        .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src_event, .external_irq_pin_zero,
        .external_irq_pin_one, .instr_boundary, .return_from_irq_instr_done, .call_start, .call_vector, .call_level,
        .call_busy, .in_service, .pending);
    core_model u_core_model (.clk, .resetn, .call_busy, .ret_req, .slow, .instr_boundary, .return_from_irq_instr_done);
    always #2.5 clk = ~clk;
    task automatic complete_run;
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk({9'h0, reg_rdata}, {9'h0, e});
    endtask
    // waits n cycles for a call; zero expects none
    task automatic watch(input logic [16:0] exp, input int n);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (k < n && !call_start);
        chk(call_start ? {call_level, call_vector} : 17'h0, exp);
        if (exp != 17'h0 && !call_start) complete_run();
    endtask
    task automatic ret(input logic [1:0] exp);
        int k;
        k = 0;
        @(posedge clk) ret_req <= 1'b1;
        @(posedge clk) ret_req <= 1'b0;
        #1;
        while (k < 20 && !return_from_irq_instr_done) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 20) n_fail++;
        if (k == 20) complete_run();
        @(posedge clk);
        #1;
        chk({15'h0, in_service}, {15'h0, exp});
    endtask
    task automatic t_regs;
        logic [7:0] ra [9] = '{8'ha8, 8'hb8, 8'he6, 8'he7, 8'hf3, 8'hf4, 8'h10, 8'h11, 8'h55};
        logic [7:0] wv [9] = '{8'h00, 8'hff, 8'h3f, 8'h03, 8'h3f, 8'h03, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++) rd(ra[i], i == 1 ? 8'h80 : 8'h00);
        for (int i = 1; i < 9; i++) begin
            if (i < 6 || i == 8) begin
                wr(ra[i], 8'hff);
                rd(ra[i], wv[i]);
                wr(ra[i], 8'h00);
            end
        end
    endtask
    task automatic t_latency;
        int k;
        wr(8'ha8, 8'h82);
        @(posedge clk) src_event <= 15'h0002;
        @(posedge clk) src_event <= 15'h0;
        k = 0;
        while (k < 10 && !call_start) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(17'(k), 17'h2);
        chk({call_level, call_vector}, 17'h0000b);
        chk({16'h0, call_busy}, 17'h00001);
        ret(2'b00);
    endtask
    task automatic t_mask;
        @(posedge clk) src_event <= 15'h0010;
        @(posedge clk) src_event <= 15'h0;
        watch(17'h0, 20);
        rd(8'h10, 8'h10);
        chk({2'h0, pending}, 17'h00010);
        wr(8'ha8, 8'h10);
        watch(17'h0, 20);
        wr(8'ha8, 8'h90);
        watch(17'h00023, 20);
        wr(8'h10, 8'h00);
        ret(2'b00);
    endtask
    task automatic t_order;
        logic [14:0] p;
        wr(8'ha8, 8'hff);
        wr(8'he6, 8'h3f);
        wr(8'he7, 8'h03);
        for (int i = 0; i < 15; i++) begin
            p = 15'h1 << i;
            if (i < 8) wr(8'h10, p[7:0]);
            else wr(8'h11, {1'b0, p[14:8]});
            watch(17'h3 + 17'(8 * (i < 13 ? i : i + 2)), 20);
            if (i < 8) rd(8'h10, i < 4 ? 8'h00 : p[7:0]);
            else rd(8'h11, {1'b0, p[14:8]});
            wr(8'h10, 8'h00);
            wr(8'h11, 8'h00);
            ret(2'b00);
        end
    endtask
    task automatic t_prio;
        wr(8'ha8, 8'h7f);
        wr(8'hf3, 8'h04);
        wr(8'h10, 8'h04);
        wr(8'h11, 8'h02);
        wr(8'ha8, 8'hff);
        watch(17'h1004b, 20);
        watch(17'h0, 20);
        wr(8'h11, 8'h00);
        ret(2'b00);
        watch(17'h00013, 20);
        wr(8'h11, 8'h02);
        watch(17'h1004b, 20);
        wr(8'h11, 8'h00);
        ret(2'b01);
        wr(8'h10, 8'h20);
        watch(17'h0, 20);
        ret(2'b00);
        watch(17'h0002b, 20);
        wr(8'h10, 8'h00);
        ret(2'b00);
        wr(8'hf3, 8'h00);
    endtask
    task automatic t_pins;
        @(posedge clk) slow <= 1'b1;
        wr(8'ha8, 8'h85);
        @(posedge clk) external_irq_pin_zero <= 1'b1;
        watch(17'h00003, 40);
        ret(2'b00);
        @(posedge clk) external_irq_pin_one <= 1'b1;
        watch(17'h00013, 40);
        ret(2'b00);
    endtask
    initial begin
        {clk, resetn, reg_wr, reg_rd, ret_req, slow} = 6'h0;
        {external_irq_pin_zero, external_irq_pin_one} = 2'h0;
        {reg_addr, reg_wdata, src_event} = 31'h0;
        {n_fail, n_compared} = 64'h0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_latency();
        t_mask();
        t_order();
        t_prio();
        t_pins();
        complete_run();
    end
endmodule // test_two_level_interrupt_controller
`default_nettype wire
